/* File: bench/rms_far_side.sv */
// Far-side model: external address filter pins and memory clock strap
`timescale 1ns/100ps
module rms_far_side
(
  input  wire logic want_match,
  input  wire logic want_exact,
  output logic      ext_dest_match_input_n,
  output logic      ext_dest_exact_input_n,
  output logic      buffer_memory_clock
);
  // Filter pins are active low, so an idle filter holds them high
  assign ext_dest_match_input_n = ~want_match;
  assign ext_dest_exact_input_n = ~want_exact;
  // Strapped to the free-running 25 MHz symbol clock
  initial
  begin
    buffer_memory_clock = 1'b0;
    forever #20 buffer_memory_clock = ~buffer_memory_clock;
  end
endmodule : rms_far_side

/* File: bench/rms_status_top_sva.sv */
// Port-level assertions for the status top
`timescale 1ns/100ps
module rms_status_top_sva
  import rms_pkg::*;
(
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic       clk_en,
  input wire logic [2:0] host_request_code,
  input wire logic       host_write,
  input wire logic       q_underrun,
  input wire logic       q_full,
  input wire logic [2:0] queue_status_pins,
  input wire logic       host_write_async1,
  input wire logic       rx_frame_abort,
  input wire logic [5:0] receive_status_pins,
  input wire logic       da_match_flag,
  input wire logic       frame_copied_flag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_qs_reserved: assert property (queue_status_pins != 3'h4)
    else $error("reserved queue code");
  a_qs_underrun: assert property (clk_en && q_underrun |=> queue_status_pins == 3'h5)
    else $error("underrun code");
  a_qs_full: assert property (clk_en && q_full && !q_underrun |=> queue_status_pins == 3'h6)
    else $error("full code");
  a_hw_async1: assert property (clk_en && host_write && host_request_code == 3'h7
    |=> host_write_async1) else $error("async 1 miss");
  a_async1_cause: assert property (host_write_async1 |-> $past(host_request_code) == 3'h7)
    else $error("async 1 cause");
  a_rxs_abort: assert property (clk_en && rx_frame_abort |=> !receive_status_pins[5]
    || receive_status_pins[4:0] == 5'h05) else $error("abort code");
  a_rxs_codes: assert property (receive_status_pins[5] |-> receive_status_pins[4:0] inside
    {5'h01, 5'h09, 5'h02, 5'h05, 5'h06}) else $error("reserved receive code");
  a_flag_pair: assert property (da_match_flag |-> frame_copied_flag)
    else $error("flag pair");
endmodule : rms_status_top_sva
bind rms_status_top rms_status_top_sva rms_status_top_sva_inst (.*);

/* File: bench/rms_status_top_tb.sv */
// Self-checking bench for the status top
`timescale 1ns/100ps
module rms_status_top_tb
  import rms_pkg::*;
;
  logic mclk, sys_rst, clk_en, reg_wr, reg_rd, frame_eval, ed_a_in, ed_c_in, tx_first_valid;
  logic internal_dest_match, want_match, want_exact, host_write, host_write_async1, bm_strobe;
  logic q_underrun, q_full, q_above_threshold, q_unload_sync, q_unload_async0, q_unload_async1;
  logic rx_sd_nondata, rx_spcl_strip, rx_frame_abort, rx_frame_flush, buffer_memory_clock;
  logic ext_dest_match_input_n, ext_dest_exact_input_n, da_match_flag, frame_copied_flag;
  logic ed_a_out, ed_c_out, da_next_word, fc_valid, cmd1_pulse, cmd2_pulse;
  logic [1:0]  fc_lane;
  logic [2:0]  host_request_code, queue_status_pins;
  logic [3:0]  rx_ev;
  logic [4:0]  legacy_rx_status;
  logic [5:0]  receive_status_pins;
  logic [7:0]  reg_addr, qi, fc_byte, cmd1_code, cmd2_code;
  logic [12:0] r;
  logic [15:0] reg_wdata, reg_rdata, tx_status_upper_in;
  logic [31:0] tx_first_word;
  int          failures, num_checks, bm_seen;
  // Rows: underrun, full, above, sync, a0, a1, write, code 111, then expected pins
  logic [10:0] q_rows [9] = '{11'h605, 11'h316, 11'h197, 11'h110, 11'h0C1, 11'h062,
                              11'h023, 11'h01B, 11'h000};
  // Rows: select, special, exact enable, exact, match, internal, A in, C in, then flags and bits
  logic [12:0] ind_rows [10] = '{13'h008F, 13'h0485, 13'h0A85, 13'h0B8F, 13'h1085,
                                 13'h138F, 13'h1862, 13'h104F, 13'h0033, 13'h098F};
  logic [5:0]  rxs_exp [4] = '{6'h21, 6'h22, 6'h26, 6'h25};
  assign {q_underrun, q_full, q_above_threshold, q_unload_sync, q_unload_async0,
          q_unload_async1, host_write} = qi[7:1];
  assign host_request_code = {3{qi[0]}};
  assign {rx_frame_abort, rx_frame_flush, rx_spcl_strip, rx_sd_nondata} = rx_ev;
  always @(posedge mclk) bm_seen += bm_strobe;
  rms_status_top rms_status_top_inst (.*);
  rms_far_side rms_far_side_inst (.*);
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    failures += int'(got !== exp);
    if (got !== exp) $display("[ERR] %0t got %h want %h", $time, got, exp);
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(reg_rdata, e);
  endtask : rd
  // Sample edge, then settle
  task automatic tick;
    @(posedge mclk);
    @(negedge mclk);
  endtask : tick
  task automatic conclude;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
  initial
  begin
    {sys_rst, clk_en, reg_wr, reg_rd, frame_eval, ed_a_in, ed_c_in, tx_first_valid} = 8'h C0;
    {internal_dest_match, want_match, want_exact, qi, rx_ev, reg_addr, reg_wdata} = '0;
    {legacy_rx_status, tx_status_upper_in, tx_first_word} = {5'h0A, 16'hFFFF, 32'h1122_3344};
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(8'h60, 16'h0000);
    for (int i = 0; i < 9; i++)
    begin
      @(posedge mclk);
      qi <= q_rows[i][10:3];
      tick();
      chk(queue_status_pins, q_rows[i][2:0]);
    end
    wr(8'h60, 16'h0002);
    qi <= 8'h22;
    repeat (3)
    begin
      tick();
      chk(queue_status_pins, 3'h7);
    end
    qi <= 8'h62;
    tick();
    chk(queue_status_pins, 3'h6);
    {qi, rx_ev} <= 12'h008;
    tick();
    chk(receive_status_pins, 6'h0A);
    $display("queue done");
    wr(8'h60, 16'h0001);
    for (int i = 0; i < 4; i++)
    begin
      rx_ev <= 4'(1 << i);
      tick();
      chk(receive_status_pins, rxs_exp[i]);
    end
    for (int i = 0; i < 10; i++)
    begin
      r = ind_rows[i];
      wr(8'h60, {10'h000, r[12:11], 1'b0, r[9], 2'h0});
      wr(8'h40, {2'h0, r[10], 13'h0000});
      {want_exact, want_match, internal_dest_match, ed_a_in, ed_c_in, rx_ev} <= {r[8:4], 4'h0};
      repeat (3) @(posedge mclk);
      frame_eval <= 1'b1;
      tick();
      frame_eval <= 1'b0;
      chk({da_match_flag, frame_copied_flag, ed_a_out, ed_c_out}, r[3:0]);
    end
    $display("indicator done");
    wr(8'h44, 16'h0012);
    @(negedge mclk);
    chk(cmd1_pulse, 1'b1);
    wr(8'h44, 16'h0018);
    @(negedge mclk);
    chk({cmd1_pulse, cmd1_code}, 9'h012);
    wr(8'h48, 16'h0008);
    @(negedge mclk);
    chk({cmd2_pulse, cmd2_code}, 9'h000);
    rd(8'h50, 16'h0777);
    rd(8'h7C, 16'h0000);
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h60, {2'h0, 2'(k), 12'h000});
      tx_first_valid <= 1'b1;
      tick();
      tx_first_valid <= 1'b0;
      chk({fc_valid, fc_lane, da_next_word, fc_byte},
          {1'b1, 2'(3 - k), k == 3, tx_first_word[8 * (3 - k) +: 8]});
    end
    $display("cmd done");
    chk(bm_seen > 0, 1'b1);
    @(posedge mclk);
    sys_rst <= 1'b1;
    tick();
    chk({fc_lane, cmd1_code, queue_status_pins}, 13'h1800);
    @(posedge mclk);
    sys_rst <= 1'b0;
    rd(8'h60, 16'h0000);
    $display("reset done");
    conclude();
  end
endmodule : rms_status_top_tb

/* File: rtl/rms_ac_decode.sv */
// Combinational A/C indicator and match flag decision
`timescale 1ns/100ps
module rms_ac_decode
  import rms_pkg::*;
(
  input  wire logic [1:0] ind_sel,
  input  wire logic       spcl_active,
  input  wire logic       exact_en,
  input  wire logic       ext_exact,
  input  wire logic       ext_match,
  input  wire logic       int_match,
  output logic            set_a_flag,
  output logic            set_c_flag,
  output logic            set_a_bit,
  output logic            set_c_bit
);

  logic exact_seen;   // Exact input, gated by its enable
  logic exact_miss;   // Enabled exact check failed
  logic ext_only;     // External match without internal match
  logic ext_full;     // External match earns both flags and bits
  logic any_set;      // Selection allows any setting at all
  logic full_set;     // Both flags and both bits

  assign exact_seen = exact_en & ext_exact; // [R20]
  assign exact_miss = exact_en & ~ext_exact; // [R20]
  assign any_set    = (ind_sel != RMS_IND_NONE); // [R8]
  assign ext_only   = ext_match & ~int_match;
  // Legacy off special mode, online bar an exact miss, special on exact
  assign ext_full   = ((ind_sel == RMS_IND_LEGACY) & ~spcl_active) // [R13]
                    | ((ind_sel == RMS_IND_ONLINE) & ~exact_miss)  // [R13]
                    | ((ind_sel == RMS_IND_SPCL) & exact_seen);    // [R12]
  assign full_set   = any_set & (int_match | (ext_only & ext_full)); // [R11] [R13]

  // With neither match all four stay low: flags clear, bits untouched [R10]
  assign set_a_flag = full_set;
  assign set_a_bit  = full_set;
  assign set_c_flag = full_set | (any_set & ext_only); // [R12]
  assign set_c_bit  = full_set | (any_set & ext_only); // [R12]

endmodule : rms_ac_decode

/* File: rtl/rms_pkg.sv */
// Constants, codes and register layout for the ring MAC status and indicator logic
// Overview of operation
// R1: Legacy five-bit receive status, sixth pin low
// R2: Extended receive codes when sixth pin high
// R3: Queue status pins follow the documented encoding
// R4: Queue status code 100 is never driven
// R5: Almost-full repeats each host write if enabled
// R6: Buffer memory timing follows buffer memory clock
// R7: Board supplies byte and symbol clocks
// R8: Indicator select picks A/C setting behaviour
// R9: Select bits 5:4, exact enable bit 2
// R10: No match clears flags, A/C unmodified
// R11: Internal match sets both flags and bits
// R12: External match sets copied flag and C only
// R13: External match sets all, exact exception
// R14: Command values 0x18 and 0x08 are reserved
// R15: Removed queue status bits read zero
// R16: Host code 111 writes async queue 1
// R17: Host writes aligned frames, FC in MSB
// R18: FC lane field bits 13:12, reset zero
// R19: Each nonzero FC lane code picks a lane
// R20: Exact inputs honoured only when enabled
package rms_pkg;

  // Register byte addresses on the plain register port
  localparam logic [7:0]  RMS_ADDR_MODE1   = 8'h40;
  localparam logic [7:0]  RMS_ADDR_CMD1    = 8'h44;
  localparam logic [7:0]  RMS_ADDR_CMD2    = 8'h48;
  localparam logic [7:0]  RMS_ADDR_TXSTAT  = 8'h50;
  localparam logic [7:0]  RMS_ADDR_STATUS  = 8'h54;
  localparam logic [7:0]  RMS_ADDR_MODE3   = 8'h60;

  // Reset values
  localparam logic [15:0] RMS_MODE1_RESET  = 16'h0000;
  localparam logic [15:0] RMS_MODE3_RESET  = 16'h0000;
  localparam logic [7:0]  RMS_CMD_RESET    = 8'h00;

  // Third mode register field positions
  localparam int RMS_M3_RX_STATUS_EN = 0;
  localparam int RMS_M3_AFULL_REPEAT = 1;
  localparam int RMS_M3_EXACT_EN     = 2;
  localparam int RMS_M3_IND_SEL_LO   = 4;
  localparam int RMS_M3_IND_SEL_HI   = 5;
  localparam int RMS_M3_FC_LANE_LO   = 12;
  localparam int RMS_M3_FC_LANE_HI   = 13;

  // First mode register operating mode field and its special online value
  localparam int         RMS_M1_MODE_LO  = 12;
  localparam int         RMS_M1_MODE_HI  = 14;
  localparam logic [2:0] RMS_MODE_SPCL   = 3'h2;

  // Reserved command values of the removed third async queue
  localparam logic [7:0] RMS_CMD1_RESERVED = 8'h18;
  localparam logic [7:0] RMS_CMD2_RESERVED = 8'h08;

  // Status bits of the removed queue, forced to zero on read
  localparam logic [15:0] RMS_TXSTAT_REMOVED_MASK = 16'hF888;

  // Extended receive status codes, low five bits with the sixth pin high
  localparam logic [4:0] RMS_RXS_SD_NONDATA = 5'h01;
  localparam logic [4:0] RMS_RXS_SPC_STRIP  = 5'h02;
  localparam logic [4:0] RMS_RXS_ABORT      = 5'h05;
  localparam logic [4:0] RMS_RXS_FLUSH      = 5'h06;

  // Queue status pin codes
  localparam logic [2:0] RMS_QS_QUIET      = 3'h0;
  localparam logic [2:0] RMS_QS_UNLOAD_SYN = 3'h1;
  localparam logic [2:0] RMS_QS_UNLOAD_A0  = 3'h2;
  localparam logic [2:0] RMS_QS_UNLOAD_A1  = 3'h3;
  localparam logic [2:0] RMS_QS_UNDERRUN   = 3'h5;
  localparam logic [2:0] RMS_QS_FULL       = 3'h6;
  localparam logic [2:0] RMS_QS_AFULL      = 3'h7;

  // Host request code that now means write to async queue 1
  localparam logic [2:0] RMS_HREQ_WRITE_A1 = 3'h7;

  // Indicator select values
  localparam logic [1:0] RMS_IND_LEGACY    = 2'h0;
  localparam logic [1:0] RMS_IND_ONLINE    = 2'h1;
  localparam logic [1:0] RMS_IND_SPCL      = 2'h2;
  localparam logic [1:0] RMS_IND_NONE      = 2'h3;

  // Almost-full report tracker states
  typedef enum logic [1:0]
  {
    RMS_AF_BELOW    = 2'b01,
    RMS_AF_REPORTED = 2'b10
  } rms_af_state_type;

endpackage : rms_pkg

/* File: rtl/rms_status_top.sv */
// Ring MAC status pin encoding, A/C indicators, command filter and FC lane logic
`timescale 1ns/100ps
module rms_status_top
  import rms_pkg::*;
(
  input  wire logic        mclk,                    // System clock
  input  wire logic        sys_rst,                 // Sync reset
  input  wire logic        clk_en,                  // Low freezes state
  input  wire logic [7:0]  reg_addr,                // Byte address
  input  wire logic [15:0] reg_wdata,               // Write data
  input  wire logic        reg_wr,                  // Write strobe
  input  wire logic        reg_rd,                  // Read strobe
  output logic      [15:0] reg_rdata,               // Read data, next cycle
  input  wire logic [4:0]  legacy_rx_status,        // Legacy receive status code
  input  wire logic        rx_sd_nondata,           // SD then non-data
  input  wire logic        rx_spcl_strip,           // Special mode strip
  input  wire logic        rx_frame_abort,          // Frame aborted
  input  wire logic        rx_frame_flush,          // Frame flushed
  output logic      [5:0]  receive_status_pins,     // Receive status pins
  input  wire logic [2:0]  host_request_code,       // Host request code
  input  wire logic        host_write,              // Host write cycle
  input  wire logic        q_unload_sync,           // Unloading synchronous queue
  input  wire logic        q_unload_async0,         // Unloading async queue 0
  input  wire logic        q_unload_async1,         // Unloading async queue 1
  input  wire logic        q_underrun,              // Current frame underrun
  input  wire logic        q_full,                  // Current queue full
  input  wire logic        q_above_threshold,       // Above almost-full mark
  output logic      [2:0]  queue_status_pins,       // Queue status pins
  output logic             host_write_async1,       // Write to async 1
  input  wire logic        buffer_memory_clock,     // Memory clock pin
  output logic             bm_strobe,               // Memory timing strobe
  input  wire logic        internal_dest_match,     // Internal DA match
  input  wire logic        ext_dest_match_input_n,  // External DA match pin
  input  wire logic        ext_dest_exact_input_n,  // External DA exact pin
  input  wire logic        frame_eval,              // Indicator update strobe
  input  wire logic        ed_a_in,                 // Received A bit
  input  wire logic        ed_c_in,                 // Received C bit
  output logic             da_match_flag,           // DA match flag
  output logic             frame_copied_flag,       // Frame copied flag
  output logic             ed_a_out,                // Repeated A bit
  output logic             ed_c_out,                // Repeated C bit
  input  wire logic [31:0] tx_first_word,           // First transmit data word
  input  wire logic        tx_first_valid,          // First word present
  output logic      [7:0]  fc_byte,                 // Extracted frame control byte
  output logic      [1:0]  fc_lane,                 // Byte lane that held FC
  output logic             da_next_word,            // DA starts in next word
  output logic             fc_valid,                // FC outputs updated
  output logic             cmd1_pulse,              // Accepted first command
  output logic      [7:0]  cmd1_code,               // Its value
  output logic             cmd2_pulse,              // Accepted second command
  output logic      [7:0]  cmd2_code,               // Its value
  input  wire logic [15:0] tx_status_upper_in       // Raw upper transmit status
);

  // Register storage
  logic [15:0] first_mode_register_reg;    // Holds operating mode field
  logic [15:0] first_mode_register_next;
  logic [15:0] third_mode_register_reg;    // Enhancement enables
  logic [15:0] third_mode_register_next;
  logic [15:0] reg_rdata_next;

  // Almost-full tracker
  rms_af_state_type af_state_reg;
  rms_af_state_type af_state_next;

  // Synchronised pins
  logic [2:0]  pin_sync;                   // BM clock, match, exact
  logic        bm_clk_s;
  logic        bm_clk_prev_reg;            // Edge detection history
  logic        ext_match_s;                // Active high after inversion
  logic        ext_exact_s;

  // Decoded mode bits
  logic        enhanced_rx_status_enable;
  logic        almost_full_repeat_enable;
  logic        exact_match_enable;
  logic        indicator_select_low;
  logic        indicator_select_high;
  logic [1:0]  indicator_select;
  logic [1:0]  fc_lane_select;
  logic        special_online_mode;

  // Address decode
  logic        hit_mode1;
  logic        hit_mode3;
  logic        hit_cmd1;
  logic        hit_cmd2;
  logic        hit_txstat;
  logic        hit_status;
  logic        wr_mode1;
  logic        wr_mode3;
  logic        cmd1_accept;
  logic        cmd2_accept;
  logic [15:0] txstat_masked;
  logic [15:0] status_word;

  // Receive status
  logic        rx_event;
  logic [4:0]  rx_ext_code;
  logic [5:0]  rx_status_next;

  // Queue status
  logic        af_event;
  logic        af_show;
  logic        host_a1;
  logic [2:0]  queue_code;

  // Indicators
  logic        set_a_flag;
  logic        set_c_flag;
  logic        set_a_bit;
  logic        set_c_bit;

  // FC placement
  logic [1:0]  lane_idx;
  logic [31:0] lane_shifted;
  logic        bm_rise;

  // Pins from outside mclk pass two flops before any use
  rms_sync #(
    .WIDTH    (3)
  ) u_pin_sync (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .async_in ({buffer_memory_clock, ext_dest_match_input_n, ext_dest_exact_input_n}),
    .sync_out (pin_sync)
  );

  // Match pins are active low at the package
  assign bm_clk_s    = pin_sync[2];
  assign ext_match_s = ~pin_sync[1];
  assign ext_exact_s = ~pin_sync[0];

  // Mode field extraction
  assign enhanced_rx_status_enable = third_mode_register_reg[RMS_M3_RX_STATUS_EN];
  assign almost_full_repeat_enable = third_mode_register_reg[RMS_M3_AFULL_REPEAT];
  assign exact_match_enable        = third_mode_register_reg[RMS_M3_EXACT_EN];      // [R9]
  assign indicator_select_low      = third_mode_register_reg[RMS_M3_IND_SEL_LO];    // [R9]
  assign indicator_select_high     = third_mode_register_reg[RMS_M3_IND_SEL_HI];    // [R9]
  assign indicator_select          = {indicator_select_high, indicator_select_low};
  assign fc_lane_select = third_mode_register_reg[RMS_M3_FC_LANE_HI:RMS_M3_FC_LANE_LO]; // [R18]
  assign special_online_mode =
    (first_mode_register_reg[RMS_M1_MODE_HI:RMS_M1_MODE_LO] == RMS_MODE_SPCL);

  // Register address decode
  assign hit_mode1  = (reg_addr == RMS_ADDR_MODE1);
  assign hit_mode3  = (reg_addr == RMS_ADDR_MODE3);
  assign hit_cmd1   = (reg_addr == RMS_ADDR_CMD1);
  assign hit_cmd2   = (reg_addr == RMS_ADDR_CMD2);
  assign hit_txstat = (reg_addr == RMS_ADDR_TXSTAT);
  assign hit_status = (reg_addr == RMS_ADDR_STATUS);
  assign wr_mode1   = reg_wr & hit_mode1;
  assign wr_mode3   = reg_wr & hit_mode3;

  // Values of the missing queue never become an instruction [R14]
  assign cmd1_accept = reg_wr & hit_cmd1 & (reg_wdata[7:0] != RMS_CMD1_RESERVED); // [R14]
  assign cmd2_accept = reg_wr & hit_cmd2 & (reg_wdata[7:0] != RMS_CMD2_RESERVED); // [R14]

  // Removed queue status bits are cut before they reach software
  assign txstat_masked = tx_status_upper_in & ~RMS_TXSTAT_REMOVED_MASK;           // [R15]

  // Live view of block state
  assign status_word = {8'h00, fc_lane, host_write_async1, (af_state_reg == RMS_AF_REPORTED),
                        ext_exact_s, ext_match_s, frame_copied_flag, da_match_flag};

  assign first_mode_register_next = wr_mode1 ? reg_wdata : first_mode_register_reg;
  // Field resets to zero with the rest of the register [R18]
  assign third_mode_register_next = wr_mode3 ? reg_wdata : third_mode_register_reg;

  // Read mux; unmapped addresses and idle cycles answer zero
  assign reg_rdata_next = ~reg_rd   ? 16'h0000 :
                          hit_mode1  ? first_mode_register_reg :
                          hit_mode3  ? third_mode_register_reg :
                          hit_cmd1   ? {8'h00, cmd1_code} :
                          hit_cmd2   ? {8'h00, cmd2_code} :
                          hit_txstat ? txstat_masked :
                          hit_status ? status_word :
                                       16'h0000;

  // Receive status: abort outranks flush, flush outranks strip and delimiter
  assign rx_event    = rx_frame_abort | rx_frame_flush | rx_spcl_strip | rx_sd_nondata;
  assign rx_ext_code = rx_frame_abort ? RMS_RXS_ABORT : // [R2]
                       rx_frame_flush ? RMS_RXS_FLUSH : // [R2]
                       rx_spcl_strip  ? RMS_RXS_SPC_STRIP : // [R2]
                                        RMS_RXS_SD_NONDATA; // [R2]
  // Legacy code with the sixth pin low unless extended codes are enabled and a receive event is present
  assign rx_status_next = (enhanced_rx_status_enable & rx_event) ?
                          {1'b1, rx_ext_code} : // [R2]
                          {1'b0, legacy_rx_status}; // [R1]

  // Almost-full shows on host writes above threshold while room remains
  assign af_event = host_write & q_above_threshold & ~q_full;            // [R5]
  assign af_show  = af_event &
                    (almost_full_repeat_enable | (af_state_reg == RMS_AF_BELOW)); // [R5]

  // Host code 111 now loads async queue 1 and reports as its unload code
  assign host_a1 = host_write & (host_request_code == RMS_HREQ_WRITE_A1); // [R16]

  // Priority encoder; only listed codes can leave it, so 100 never appears
  assign queue_code = q_underrun      ? RMS_QS_UNDERRUN : // [R3]
                      q_full          ? RMS_QS_FULL : // [R3]
                      af_show         ? RMS_QS_AFULL : // [R3] [R5]
                      q_unload_sync   ? RMS_QS_UNLOAD_SYN : // [R3]
                      q_unload_async0 ? RMS_QS_UNLOAD_A0 : // [R3]
                      (q_unload_async1 | host_a1) ? RMS_QS_UNLOAD_A1 : // [R4] [R16]
                                        RMS_QS_QUIET; // [R3] [R4]

  // Tracker rearms once below threshold
  always_comb
  begin
    af_state_next = af_state_reg;
    unique case (af_state_reg)
      RMS_AF_BELOW:
      begin
        if (af_show)
        begin
          af_state_next = RMS_AF_REPORTED; // [R5]
        end
      end
      RMS_AF_REPORTED:
      begin
        if (~q_above_threshold)
        begin
          af_state_next = RMS_AF_BELOW; // [R5]
        end
      end
      default:
      begin
        af_state_next = RMS_AF_BELOW; // Recover
      end
    endcase
  end

  // A/C decision from both match sources
  rms_ac_decode u_ac_decode (
    .ind_sel    (indicator_select),
    .spcl_active (special_online_mode),
    .exact_en   (exact_match_enable),
    .ext_exact  (ext_exact_s),
    .ext_match  (ext_match_s),
    .int_match  (internal_dest_match),
    .set_a_flag (set_a_flag),
    .set_c_flag (set_c_flag),
    .set_a_bit  (set_a_bit),
    .set_c_bit  (set_c_bit)
  );

  // FC lane: 00 keeps the MSB lane, other codes walk down one lane each
  assign lane_idx     = 2'd3 - fc_lane_select; // [R19]
  assign lane_shifted = tx_first_word >> {lane_idx, 3'b000}; // [R18]

  // Rising edge of the synchronised buffer memory clock
  assign bm_rise = bm_clk_s & ~bm_clk_prev_reg; // [R6]

  // Register file and read data
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      first_mode_register_reg <= RMS_MODE1_RESET;
      third_mode_register_reg <= RMS_MODE3_RESET;
      reg_rdata               <= 16'h0000;
    end
    else if (clk_en)
    begin
      first_mode_register_reg <= first_mode_register_next;
      third_mode_register_reg <= third_mode_register_next;
      reg_rdata               <= reg_rdata_next;
    end
  end

  // Command outputs; a reserved value leaves the last code and no pulse
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      cmd1_pulse <= 1'b0;
      cmd2_pulse <= 1'b0;
      cmd1_code  <= RMS_CMD_RESET;
      cmd2_code  <= RMS_CMD_RESET;
    end
    else if (clk_en)
    begin
      cmd1_pulse <= cmd1_accept; // [R14]
      cmd2_pulse <= cmd2_accept; // [R14]
      if (cmd1_accept)
      begin
        cmd1_code <= reg_wdata[7:0];
      end
      if (cmd2_accept)
      begin
        cmd2_code <= reg_wdata[7:0];
      end
    end
  end

  // Status pins are registered so they change only on mclk edges
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      receive_status_pins <= 6'h00;
      queue_status_pins   <= RMS_QS_QUIET;
      host_write_async1   <= 1'b0;
      af_state_reg        <= RMS_AF_BELOW;
    end
    else if (clk_en)
    begin
      receive_status_pins <= rx_status_next; // [R1] [R2]
      queue_status_pins   <= queue_code; // [R3]
      host_write_async1   <= host_a1; // [R16]
      af_state_reg        <= af_state_next;
    end
  end

  // Indicators update once per frame at the evaluation strobe
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      da_match_flag     <= 1'b0;
      frame_copied_flag <= 1'b0;
      ed_a_out          <= 1'b0;
      ed_c_out          <= 1'b0;
    end
    else if (clk_en & frame_eval)
    begin
      da_match_flag     <= set_a_flag; // [R10] [R11]
      frame_copied_flag <= set_c_flag; // [R10] [R12]
      ed_a_out          <= set_a_bit | ed_a_in; // [R10] [R13]
      ed_c_out          <= set_c_bit | ed_c_in; // [R10] [R12]
    end
  end

  // FC placement result, captured with the first word
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      fc_byte      <= 8'h00;
      fc_lane      <= 2'h3;
      da_next_word <= 1'b0;
      fc_valid     <= 1'b0;
    end
    else if (clk_en)
    begin
      fc_valid <= tx_first_valid;
      if (tx_first_valid)
      begin
        fc_byte      <= lane_shifted[7:0]; // [R18]
        fc_lane      <= lane_idx; // [R19]
        da_next_word <= (lane_idx == 2'h0); // [R18]
      end
    end
  end

  // Sampled at 40 MHz a 25 MHz clock aliases, so the strobe marks the
  // edges that the sampler sees; buffer memory timing keys off it only
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      bm_clk_prev_reg <= 1'b0;
      bm_strobe       <= 1'b0;
    end
    else if (clk_en)
    begin
      bm_clk_prev_reg <= bm_clk_s;
      bm_strobe       <= bm_rise; // [R6]
    end
  end

endmodule : rms_status_top

/* File: rtl/rms_sync.sv */
// Two flip-flop synchroniser for pins from outside the mclk domain
`timescale 1ns/100ps
module rms_sync
  import rms_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;   // First stage, read only by the second

  // Both stages freeze with the clock enable like all other state
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      stage1_reg <= '0;
      sync_out   <= '0;
    end
    else if (clk_en)
    begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end

endmodule : rms_sync
